// File: rtl/amux_pkg.sv
package amux_pkg;

    // display fetch modes
    typedef enum logic [2:0] {
        MODE_BYTE = 3'h0,
        MODE_WORD = 3'h1,
        MODE_DWORD = 3'h2,
        MODE_TEXT_STD = 3'h3,
        MODE_TEXT_ENH = 3'h4
    } fetch_mode_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ROW = 2'h1,
        PH_COL = 2'h2
    } phase_type;

    // control fields carried together
    typedef struct packed {
        fetch_mode_type mode;
        logic wordMode16;
        logic asym;
        logic linearMode;
        logic mem512k;
        logic [4:0] bankReg;
        logic extendedMemoryFlag;
        logic oddEven;
        logic [1:0] gfxMemMap;
        logic fourPlaneChaining;
        logic highPageBit;
    } amux_ctrl_type;

    // register indices and bit positions
    localparam logic [7:0] SEQ_MEMMODE_INDEX = 8'h04;
    localparam int SEQ_EXTENDED_MEMORY_FLAG_BIT = 1;
    localparam int SEQ_FOUR_PLANE_CHAINING_BIT = 3;
    localparam logic [7:0] GFX_MISC_INDEX = 8'h06;
    localparam int GFX_ODDEVEN_BIT = 1;
    localparam int GFX_MAP_LO_BIT = 2;
    localparam int GFX_MAP_HI_BIT = 3;
    localparam int MISC_PAGE_BIT = 5;
    localparam int PAGE_LINE_256K = 2;
    localparam int PAGE_LINE_512K = 3;
    localparam int ADDR_LINES = 10;
    localparam int FETCH_BITS = 18;

    // register apb offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SEQ04 = 12'h004;
    localparam logic [11:0] OFS_GFX06 = 12'h008;
    localparam logic [11:0] OFS_MISC = 12'h00c;
    localparam logic [11:0] OFS_BANK = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] GFX06_RESET = 32'h0000_0000;

endpackage

// File: rtl/amux_select.sv
module amux_select
    import amux_pkg::*;
(
    input wire amux_ctrl_type ctrl,
    input wire logic [20:0] hostAddr,
    output logic [4:0] upperPage,
    output logic pageSelect,
    output logic planePairSelect,
    output logic thirdLaneSelect,
    output logic legacyWindow128k
);
    wire [4:0] linearPage = hostAddr[20:16];
    wire laneLine = ctrl.mem512k ? upperPage[PAGE_LINE_512K]
                                 : upperPage[PAGE_LINE_256K];
    wire mapLo = ctrl.gfxMemMap[0];
    wire mapHi = ctrl.gfxMemMap[1];
    wire altPage;
    wire basePage;

    assign upperPage = ctrl.linearMode ? linearPage : ctrl.bankReg;
    // mixed map codes keep the window closed
    assign legacyWindow128k = !mapLo && !mapHi;
    assign altPage = !ctrl.extendedMemoryFlag ? hostAddr[14] :
                     legacyWindow128k ? hostAddr[16] :
                     !ctrl.highPageBit;
    assign basePage = ctrl.oddEven ? altPage : hostAddr[0];
    // word mode page select comes from the upper page line unless chaining forces it to 0
    assign pageSelect = ctrl.fourPlaneChaining ? 1'b0 :
                        (ctrl.mode == MODE_WORD) ? laneLine :
                        basePage;
    assign planePairSelect = ctrl.fourPlaneChaining ? 1'b0
                                                    : hostAddr[1];
    assign thirdLaneSelect = (ctrl.mode == MODE_DWORD) ? laneLine
                                                       : hostAddr[2];
endmodule

// File: rtl/display_fetch_dram_addr_mux.sv
// How it works
// - graphics modes put fetch address bits from column line 1 up, line 0 is lane or bit 17, line 8 is 0.
// - upper page lines come from the bank register or host bits 16..20 by addressing mode.
// - lane select uses page line 2 for 256K and line 3 for 512k memory.
// - page select is host bit 0 with alternate addressing off outside word mode, and 0 when chaining is on.
// - alternate addressing picks host bit 14, host bit 16 or inverted high page bit.
// - the high page bit is bit 5 of the miscellaneous output register.
// - the 128K window is 1 when map bits 2 and 3 are both 0.
// - chaining is sequencer index 04 bit 3, extended memory is its bit 1.
//
// Our own choices: the address map and register access over APB.
module display_fetch_dram_addr_mux
    import amux_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fetchReq,
    input wire logic [FETCH_BITS-1:0] display_fetch_addr,
    input wire logic [4:0] scan_row_line,
    input wire logic [7:0] glyph_code,
    input wire logic [2:0] font_map_bits,
    input wire logic [20:0] host_addr_bit,
    output logic [ADDR_LINES-1:0] dramAddr,
    output logic rowStrobe,
    output logic colStrobe,
    output logic fetchBusy,
    output logic [4:0] upperPage,
    output logic page_select,
    output logic plane_pair_select,
    output logic third_lane_select
);
    // =============================================
    // register file
    logic [31:0] ctrlReg;
    logic [7:0] seqReg;
    logic [7:0] gfxReg;
    logic [7:0] miscReg;
    logic [4:0] bankReg;
    wire wrEn = psel && penable && pwrite;
    wire hitCtrl = paddr == OFS_CTRL;
    wire hitSeq = paddr == OFS_SEQ04;
    wire hitGfx = paddr == OFS_GFX06;
    wire hitMisc = paddr == OFS_MISC;
    wire hitBank = paddr == OFS_BANK;
    wire hitStat = paddr == OFS_STATUS;
    wire mapped = hitCtrl || hitSeq || hitGfx || hitMisc || hitBank || hitStat;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlReg <= CTRL_RESET;
            seqReg <= 8'h00;
            gfxReg <= GFX06_RESET[7:0];
            miscReg <= 8'h00;
            bankReg <= 5'h00;
        end else if (wrEn) begin
            if (hitCtrl) ctrlReg <= pwdata;
            if (hitSeq) seqReg <= pwdata[7:0];
            if (hitGfx) gfxReg <= pwdata[7:0];
            if (hitMisc) miscReg <= pwdata[7:0];
            if (hitBank) bankReg <= pwdata[4:0];
        end
    end

    // =============================================
    // control decode
    amux_ctrl_type ctrl;
    fetch_mode_type modeSel;
    logic [2:0] liveMode;
    assign liveMode = ctrlReg[2:0];
    assign modeSel = (liveMode > 3'h4) ? MODE_BYTE
                                       : fetch_mode_type'(liveMode);
    logic [6:0] heldMode;
    phase_type phase;
    assign ctrl.mode = fetch_mode_type'(heldMode[2:0]);
    assign ctrl.wordMode16 = heldMode[3];
    assign ctrl.asym = heldMode[4];
    assign ctrl.linearMode = ctrlReg[5];
    assign ctrl.mem512k = heldMode[5];
    assign ctrl.bankReg = bankReg;
    assign ctrl.extendedMemoryFlag = seqReg[SEQ_EXTENDED_MEMORY_FLAG_BIT];
    assign ctrl.fourPlaneChaining = seqReg[SEQ_FOUR_PLANE_CHAINING_BIT];
    assign ctrl.oddEven = gfxReg[GFX_ODDEVEN_BIT];
    assign ctrl.gfxMemMap = {gfxReg[GFX_MAP_HI_BIT], gfxReg[GFX_MAP_LO_BIT]};
    assign ctrl.highPageBit = miscReg[MISC_PAGE_BIT];

    logic [4:0] nextPage;
    logic nextPg;
    logic nextPair;
    logic nextLane;
    logic window128k;
    amux_select selector (
        .ctrl(ctrl),
        .hostAddr(host_addr_bit),
        .upperPage(nextPage),
        .pageSelect(nextPg),
        .planePairSelect(nextPair),
        .thirdLaneSelect(nextLane),
        .legacyWindow128k(window128k)
    );

    // =============================================
    // row and column maps
    wire [17:0] ma = display_fetch_addr;
    wire [4:0] ra = scan_row_line;
    wire [7:0] gc = glyph_code;
    wire [2:0] fm = font_map_bits;
    wire laneBit = ctrl.wordMode16 ? nextLane : nextPair;
    wire col0 = ctrl.asym ? ma[17] : laneBit;
    wire rowTop = ctrl.asym ? 1'b0 : ma[16];
    // only a 16-bit bus gives two row lines to the scan row counter
    wire [1:0] midByte = ctrl.wordMode16 ? ra[1:0] : ma[14:13];
    wire [1:0] midWord = ctrl.wordMode16 ? ra[1:0] : ma[13:12];
    wire [1:0] midDword = ctrl.wordMode16 ? ra[1:0] : ma[12:11];
    logic [ADDR_LINES-1:0] colAddr;
    logic [ADDR_LINES-1:0] rowAddr;

    always_comb begin
        colAddr = '0;
        rowAddr = '0;
        unique case (ctrl.mode)
            MODE_BYTE: begin
                colAddr = {2'b00, ma[6:0], col0};
                rowAddr = {rowTop, ma[15], midByte, ma[12:7]};
            end
            MODE_WORD: begin
                colAddr = {2'b00, ma[5:0], ctrl.wordMode16 ? ma[13] : ma[15],
                           col0};
                rowAddr = {rowTop, ma[14], midWord, ma[11:6]};
            end
            MODE_DWORD: begin
                colAddr = {2'b00, ma[4:0], ma[15], ma[14], col0};
                rowAddr = {rowTop, ma[13], midDword, ma[10:5]};
            end
            MODE_TEXT_STD: begin
                colAddr = {2'b00, gc[1:0], ra[4:0], col0};
                rowAddr = {1'b0, fm[1], fm[0], fm[2], gc[7:2]};
            end
            MODE_TEXT_ENH: begin
                colAddr = {2'b00, gc[6:0], ctrl.asym ? gc[7] : laneBit};
                rowAddr = {1'b0, fm[1], fm[0], fm[2], 1'b0, ra[4:0]};
            end
            default: begin
                colAddr = '0;
                rowAddr = '0;
            end
        endcase
    end

    // =============================================
    // row then column sequence
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= PH_IDLE;
            heldMode <= 7'h00;
            dramAddr <= '0;
            rowStrobe <= 1'b0;
            colStrobe <= 1'b0;
            upperPage <= 5'h00;
            page_select <= 1'b0;
            plane_pair_select <= 1'b0;
            third_lane_select <= 1'b0;
        end else begin
            rowStrobe <= 1'b0;
            colStrobe <= 1'b0;
            unique case (phase)
                PH_IDLE: begin
                    // mode, bus, asym and 512K flags are latched; the linear bit and other registers stay live during an access
                    heldMode <= {1'b0, ctrlReg[6], ctrlReg[4], ctrlReg[3],
                                 modeSel};
                    if (fetchReq) phase <= PH_ROW;
                end
                PH_ROW: begin
                    dramAddr <= rowAddr;
                    rowStrobe <= 1'b1;
                    upperPage <= nextPage;
                    page_select <= nextPg;
                    plane_pair_select <= nextPair;
                    third_lane_select <= nextLane;
                    phase <= PH_COL;
                end
                PH_COL: begin
                    dramAddr <= colAddr;
                    colStrobe <= 1'b1;
                    phase <= PH_IDLE;
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end
    assign fetchBusy = phase != PH_IDLE;

    // =============================================
    // status readback
    assign prdata = !psel ? 32'h0000_0000 :
                    hitCtrl ? ctrlReg :
                    hitSeq ? {24'h000000, seqReg} :
                    hitGfx ? {24'h000000, gfxReg} :
                    hitMisc ? {24'h000000, miscReg} :
                    hitBank ? {27'h0000000, bankReg} :
                    hitStat ? {25'h0000000, window128k, phase, heldMode[3:0]} :
                    32'h0000_0000;

    AST_ROW_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe |=> colStrobe) else $error("column did not follow row");
    AST_COL_AFTER_ROW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        colStrobe |-> $past(rowStrobe)) else $error("column without row");
    AST_CAS8_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        colStrobe |-> dramAddr[8] == 1'b0) else $error("col line 8 high");
    AST_CHAIN_PAGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe && $past(ctrl.fourPlaneChaining) |-> !page_select)
        else $error("page select not forced");
    AST_CHAIN_PAIR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe && $past(ctrl.fourPlaneChaining) |-> !plane_pair_select)
        else $error("pair select not forced");
    AST_LINEAR_PAGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe && $past(ctrl.linearMode)
        |-> upperPage == $past(host_addr_bit[20:16]))
        else $error("linear page wrong");
    AST_BANK_PAGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe && !$past(ctrl.linearMode) |-> upperPage == $past(bankReg))
        else $error("bank page wrong");
    AST_WINDOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        gfxReg[3:2] == 2'b11 |-> !window128k)
        else $error("window flag wrong");
    AST_TEXT_TOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rowStrobe && $past(ctrl.mode) inside {MODE_TEXT_STD, MODE_TEXT_ENH}
        |-> dramAddr[9] == 1'b0) else $error("text top row high");
endmodule

// File: verification/display_fetch_dram_addr_mux_tb.sv
module display_fetch_dram_addr_mux_tb
    import amux_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fetchReq = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rowStrobe, colStrobe, busy, done, fault;
    logic [FETCH_BITS-1:0] ma = '0;
    logic [4:0] sr = 5'h00, upper;
    logic [7:0] glyph = 8'h00;
    logic [2:0] fmap = 3'h0;
    logic [20:0] host = 21'h0;
    logic [9:0] dramAddr, rowL, colL;
    logic ps, pp, tl;
    logic [25:0] expQ[$];
    int miscompares = 0, cmp_count = 0;
    integer seed = 32'h89bf;

    always #12.5 ref_clk = ~ref_clk;

    display_fetch_dram_addr_mux DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetchReq(fetchReq), .display_fetch_addr(ma),
        .scan_row_line(sr), .glyph_code(glyph), .font_map_bits(fmap),
        .host_addr_bit(host), .dramAddr(dramAddr), .rowStrobe(rowStrobe),
        .colStrobe(colStrobe), .fetchBusy(busy), .upperPage(upper),
        .page_select(ps), .plane_pair_select(pp), .third_lane_select(tl));
    dram_addr_model model (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .dramAddr(dramAddr), .rowStrobe(rowStrobe), .colStrobe(colStrobe),
        .rowLatched(rowL), .colLatched(colL), .accessDone(done),
        .orderFault(fault));

    // ==========================================
    // reporting
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================
    // apb master and expected fetch results
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function logic [25:0] expect_of(input logic [2:0] mode,
        input logic [11:0] r, input logic ch4, input logic [1:0] map);
        logic [9:0] row;
        logic [7:0] col;
        logic [4:0] up;
        logic line, pg;
        case (mode)
            3'h0: {row, col} = {ma[16:7], 1'b0, ma[6:0]};
            3'h1: {row, col} = {ma[16], ma[14:6], 1'b0, ma[5:0], ma[15]};
            3'h2: {row, col} = {ma[16], ma[13:5], 1'b0, ma[4:0], ma[15:14]};
            3'h3: {row, col} = {1'b0, fmap[1:0], fmap[2], glyph[7:2],
                1'b0, glyph[1:0], sr};
            default: {row, col} = {1'b0, fmap[1:0], fmap[2], 1'b0, sr,
                1'b0, glyph[6:0]};
        endcase
        up = r[0] ? host[20:16] : r[6:2];
        line = r[1] ? up[3] : up[2];
        if (ch4)
            pg = 1'b0;
        else if (!r[8])
            pg = host[0];
        else if (!r[7])
            pg = host[14];
        else if (map == 2'b00)
            pg = host[16];
        else
            pg = ~r[11];
        if (mode == 3'h1)
            pg = line;
        return {row, col, up, pg, ch4 ? 1'b0 : host[1],
            mode == 3'h2 ? line : host[2]};
    endfunction

    // ==========================================
    // watcher: oldest note against each finished access
    always @(posedge ref_clk) begin
        if (done === 1'b1) begin
            if (expQ.size() == 0)
                check(32'h1, 32'h0);
            else
                check({fault, rowL, colL[8:1], upper, ps, pp, tl},
                    {1'b0, expQ.pop_front()});
        end
    end

    initial begin
        #2000000;
        miscompares++;
        conclude();
    end

    initial begin
        int i, n;
        logic [2:0] mode;
        logic [11:0] r;
        logic ch4;
        logic [1:0] map;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b1, 12'h020, 32'hffff_ffff);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        for (i = 0; i < 60; i++) begin
            mode = 3'(i % 5);
            r = 12'($random(seed));
            ch4 = ($random(seed) & 1) == 1 && mode != 3'h1;
            map = r[9] ? 2'b00 : (r[10] ? 2'b11 : 2'b01);
            // window set without extended memory is not tried; its page would be host bit 14
            if (!r[7] && map == 2'b00)
                map = 2'b11;
            apb(1'b1, OFS_CTRL, {25'h0, r[1], r[0], 2'b00, mode});
            apb(1'b1, OFS_SEQ04, {28'h0, ch4, 1'b0, r[7], 1'b0});
            apb(1'b1, OFS_GFX06, {28'h0, map, r[8], 1'b0});
            apb(1'b1, OFS_MISC, {26'h0, r[11], 5'h00});
            apb(1'b1, OFS_BANK, {27'h0, r[6:2]});
            apb(1'b0, OFS_BANK, 32'h0);
            check(rd, {27'h0, r[6:2]});
            ma <= FETCH_BITS'($random(seed));
            sr <= 5'($random(seed));
            glyph <= 8'($random(seed));
            fmap <= 3'($random(seed));
            host <= 21'($random(seed));
            @(posedge ref_clk);
            fetchReq <= 1'b1;
            expQ.push_back(expect_of(mode, r, ch4, map));
            // held a second edge while busy: must not start again
            repeat (2) @(posedge ref_clk);
            fetchReq <= 1'b0;
            check({31'h0, busy}, 32'h1);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (done !== 1'b1 && n < 20);
            if (n >= 20) begin
                miscompares++;
                conclude();
            end
        end
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule

// File: verification/dram_addr_model.sv
// ==========================================
// far-side dram: latches row then column
module dram_addr_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [9:0] dramAddr,
    input wire logic rowStrobe,
    input wire logic colStrobe,
    output logic [9:0] rowLatched,
    output logic [9:0] colLatched,
    output logic accessDone,
    output logic orderFault
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rowOpen;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rowOpen <= 1'b0;
            rowLatched <= 10'h000;
            colLatched <= 10'h000;
            accessDone <= 1'b0;
            orderFault <= 1'b0;
        end else begin
            accessDone <= 1'b0;
            if (rowStrobe) begin
                rowLatched <= dramAddr;
                rowOpen <= 1'b1;
            end
            if (colStrobe) begin
                colLatched <= dramAddr;
                accessDone <= rowOpen;
                // a column without an open row is a broken access
                orderFault <= !rowOpen;
                rowOpen <= 1'b0;
            end
        end
    end
endmodule
